// ---- logic/pcaer_cap_regs.sv ----
`timescale 1ns/1ps
module pcaer_cap_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic dsn_enable,
  input wire logic [63:0] serial_number,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_hit,
  input wire logic [31:0] unc_err_evt,
  input wire logic [15:0] cor_err_evt,
  input wire logic [127:0] err_header,
  input wire logic msg_ack,
  output logic msg_req,
  output pcaer_pkg::pcaer_msg_t msg_type
);
  // ----------------------------------------------------------------------
  // Byte-lane write mask and access decode.
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [3:0] first_pos(input logic [31:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        pos = 5'(i);
      end
    end
    first_pos = pos[3:0];
  endfunction

  pcaer_err_if err ();

  logic aer_sel;
  logic dsn_sel;
  logic [7:0] ofs;
  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] wbits;

  logic [31:0] unc_flags_ff;
  logic [31:0] unc_suppress_ff;
  logic [31:0] unc_fatality_ff;
  logic [15:0] cor_flags_ff;
  logic [15:0] cor_suppress_ff;
  logic [3:0] first_err_ff;
  logic first_valid_ff;
  logic [127:0] hdr_log_ff;
  logic [31:0] cfg_rdata_ff;
  logic cfg_rvalid_ff;
  logic cfg_hit_ff;

  logic [31:0] unc_evt;
  logic [15:0] cor_evt;
  logic [31:0] unc_clr;
  logic [15:0] cor_clr;
  logic [31:0] nxt_unc_flags;
  logic [15:0] nxt_cor_flags;
  logic [31:0] nxt_rdata;
  logic nxt_hit;
  logic [11:0] next_ptr;

  assign aer_sel = (cfg_addr[11:6] == pcaer_pkg::AER_BASE[11:6]);
  assign dsn_sel = dsn_enable &&
                   (cfg_addr[11:4] == pcaer_pkg::DSN_BASE[11:4]);
  assign ofs = {cfg_addr[7:2] - pcaer_pkg::AER_BASE[7:2], 2'b00};
  assign wr_en = cfg_req & cfg_wr & aer_sel;
  assign wmask = lane_mask(cfg_be);
  assign wbits = cfg_wdata & wmask;

  // ----------------------------------------------------------------------
  // Status flags: hardware set wins over a software clear.
  // ----------------------------------------------------------------------
  assign unc_evt = unc_err_evt & pcaer_pkg::UNC_IMPL;
  assign cor_evt = cor_err_evt & pcaer_pkg::COR_IMPL;
  assign unc_clr = (wr_en && ofs == pcaer_pkg::OFS_UNC_FLAGS) ?
                   wbits : 32'h0000_0000;
  assign cor_clr = (wr_en && ofs == pcaer_pkg::OFS_COR_FLAGS) ?
                   wbits[15:0] : 16'h0000;
  assign nxt_unc_flags = ((unc_flags_ff & ~unc_clr) | unc_evt) &
                         pcaer_pkg::UNC_IMPL;
  assign nxt_cor_flags = ((cor_flags_ff & ~cor_clr) | cor_evt) &
                         pcaer_pkg::COR_IMPL;

  always_ff @(posedge clk) begin
    if (!por_n) begin
      unc_flags_ff <= pcaer_pkg::UNC_FLAGS_RST;
      cor_flags_ff <= pcaer_pkg::COR_FLAGS_RST;
    end else begin
      unc_flags_ff <= nxt_unc_flags;
      cor_flags_ff <= nxt_cor_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Mask and severity controls.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!por_n) begin
      unc_suppress_ff <= pcaer_pkg::UNC_SUPPRESS_RST;
      unc_fatality_ff <= pcaer_pkg::UNC_FATALITY_RST;
      cor_suppress_ff <= pcaer_pkg::COR_SUPPRESS_RST;
    end else if (wr_en) begin
      if (ofs == pcaer_pkg::OFS_UNC_SUPPRESS) begin
        unc_suppress_ff <= ((unc_suppress_ff & ~wmask) | wbits) &
                           pcaer_pkg::UNC_IMPL;
      end else if (ofs == pcaer_pkg::OFS_UNC_FATALITY) begin
        unc_fatality_ff <= ((unc_fatality_ff & ~wmask) | wbits) &
                           pcaer_pkg::UNC_IMPL;
      end else if (ofs == pcaer_pkg::OFS_COR_SUPPRESS) begin
        cor_suppress_ff <= ((cor_suppress_ff & ~wmask[15:0]) |
                           wbits[15:0]) & pcaer_pkg::COR_IMPL;
      end
    end
  end

  // ----------------------------------------------------------------------
  // First error pointer and header log.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!por_n) begin
      first_err_ff <= pcaer_pkg::FIRST_ERR_RST;
      first_valid_ff <= 1'b0;
      hdr_log_ff <= pcaer_pkg::HDR_LOG_RST;
    end else if (!first_valid_ff && (|unc_evt)) begin
      first_err_ff <= first_pos(unc_evt);
      first_valid_ff <= 1'b1;
      hdr_log_ff <= err_header;
    end else if (first_valid_ff && !(|nxt_unc_flags)) begin
      first_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------------
  assign next_ptr = dsn_enable ? pcaer_pkg::DSN_BASE :
                    pcaer_pkg::NEXT_END;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_hit = 1'b1;
    if (aer_sel) begin
      if (ofs == pcaer_pkg::OFS_HEADER) begin
        nxt_rdata = {next_ptr, pcaer_pkg::CAP_VERSION,
                     pcaer_pkg::AER_CAP_ID};
      end else if (ofs == pcaer_pkg::OFS_UNC_FLAGS) begin
        nxt_rdata = unc_flags_ff;
      end else if (ofs == pcaer_pkg::OFS_UNC_SUPPRESS) begin
        nxt_rdata = unc_suppress_ff;
      end else if (ofs == pcaer_pkg::OFS_UNC_FATALITY) begin
        nxt_rdata = unc_fatality_ff;
      end else if (ofs == pcaer_pkg::OFS_COR_FLAGS) begin
        nxt_rdata = {16'h0000, cor_flags_ff};
      end else if (ofs == pcaer_pkg::OFS_COR_SUPPRESS) begin
        nxt_rdata = {16'h0000, cor_suppress_ff};
      end else if (ofs == pcaer_pkg::OFS_FIRST_ERR) begin
        nxt_rdata = {28'h0000000, first_err_ff};
      end else if (ofs >= pcaer_pkg::OFS_HDR_LOG0 &&
                   ofs <= pcaer_pkg::OFS_HDR_LOG3) begin
        nxt_rdata = hdr_log_ff[32 * (ofs[5:2] -
                    pcaer_pkg::OFS_HDR_LOG0[5:2]) +: 32];
      end
    end else if (dsn_sel) begin
      if (cfg_addr[3:0] == pcaer_pkg::OFS_DSN_HEADER[3:0]) begin
        nxt_rdata = {pcaer_pkg::NEXT_END, pcaer_pkg::CAP_VERSION,
                     pcaer_pkg::DSN_CAP_ID};
      end else if (cfg_addr[3:0] == pcaer_pkg::OFS_DSN_LOW[3:0]) begin
        nxt_rdata = serial_number[31:0];
      end else if (cfg_addr[3:0] == pcaer_pkg::OFS_DSN_HIGH[3:0]) begin
        nxt_rdata = serial_number[63:32];
      end
    end else begin
      nxt_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata_ff <= 32'h0000_0000;
      cfg_rvalid_ff <= 1'b0;
      cfg_hit_ff <= 1'b0;
    end else begin
      cfg_rvalid_ff <= cfg_req & ~cfg_wr;
      cfg_hit_ff <= cfg_req & nxt_hit;
      if (cfg_req && !cfg_wr) begin
        cfg_rdata_ff <= nxt_rdata;
      end
    end
  end

  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_rvalid = cfg_rvalid_ff;
  assign cfg_hit = cfg_hit_ff;

  // ----------------------------------------------------------------------
  // Error message generation.
  // ----------------------------------------------------------------------
  assign err.unc_pending = unc_evt;
  assign err.cor_pending = cor_evt;
  assign err.unc_suppress = unc_suppress_ff;
  assign err.unc_fatality = unc_fatality_ff;
  assign err.cor_suppress = cor_suppress_ff;
  assign err.msg_ready = 1'b1;

  pcaer_msg_gen u_msg (
    .clk(clk),
    .rst_n(rst_n),
    .err(err),
    .msg_ack(msg_ack),
    .msg_req(msg_req),
    .msg_type(msg_type)
  );
endmodule

// ---- logic/pcaer_err_if.sv ----
`timescale 1ns/1ps
interface pcaer_err_if;
  logic [31:0] unc_pending;
  logic [15:0] cor_pending;
  logic [31:0] unc_suppress;
  logic [31:0] unc_fatality;
  logic [15:0] cor_suppress;
  logic msg_valid;
  logic msg_ready;
  pcaer_pkg::pcaer_msg_t msg_kind;

  modport regs (
    output unc_pending,
    output cor_pending,
    output unc_suppress,
    output unc_fatality,
    output cor_suppress,
    input msg_valid,
    input msg_kind,
    output msg_ready
  );
  modport msgr (
    input unc_pending,
    input cor_pending,
    input unc_suppress,
    input unc_fatality,
    input cor_suppress,
    output msg_valid,
    output msg_kind,
    input msg_ready
  );
endinterface

// ---- logic/pcaer_msg_gen.sv ----
`timescale 1ns/1ps
module pcaer_msg_gen (
  input wire logic clk,
  input wire logic rst_n,
  pcaer_err_if.msgr err,
  input wire logic msg_ack,
  output logic msg_req,
  output pcaer_pkg::pcaer_msg_t msg_type
);
  // ----------------------------------------------------------------------
  // Error message requests, fatal first, then non-fatal, then correctable.
  // ----------------------------------------------------------------------
  logic [31:0] unc_send;
  logic [15:0] cor_send;
  logic fatal_any;
  logic nonfatal_any;
  logic msg_req_ff;
  pcaer_pkg::pcaer_msg_t msg_type_ff;

  assign unc_send = err.unc_pending & ~err.unc_suppress;
  assign cor_send = err.cor_pending & ~err.cor_suppress;
  assign fatal_any = |(unc_send & err.unc_fatality);
  assign nonfatal_any = |(unc_send & ~err.unc_fatality);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msg_req_ff <= 1'b0;
      msg_type_ff <= pcaer_pkg::PCAER_MSG_COR;
    end else if (!msg_req_ff || msg_ack) begin
      msg_req_ff <= fatal_any | nonfatal_any | (|cor_send);
      if (fatal_any) begin
        msg_type_ff <= pcaer_pkg::PCAER_MSG_FATAL;
      end else if (nonfatal_any) begin
        msg_type_ff <= pcaer_pkg::PCAER_MSG_NONFATAL;
      end else begin
        msg_type_ff <= pcaer_pkg::PCAER_MSG_COR;
      end
    end
  end

  assign msg_req = msg_req_ff;
  assign msg_type = msg_type_ff;
  assign err.msg_valid = msg_req_ff & msg_ack;
  assign err.msg_kind = msg_type_ff;
endmodule

// ---- logic/pcaer_pkg.sv ----
package pcaer_pkg;
  // ----------------------------------------------------------------------
  // Configuration space placement.
  // ----------------------------------------------------------------------
  localparam logic [11:0] AER_BASE = 12'h100;
  localparam logic [11:0] DSN_BASE = 12'h140;

  // ----------------------------------------------------------------------
  // Register offsets relative to the capability base.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_HEADER = 8'h00;
  localparam logic [7:0] OFS_UNC_FLAGS = 8'h04;
  localparam logic [7:0] OFS_UNC_SUPPRESS = 8'h08;
  localparam logic [7:0] OFS_UNC_FATALITY = 8'h0c;
  localparam logic [7:0] OFS_COR_FLAGS = 8'h10;
  localparam logic [7:0] OFS_COR_SUPPRESS = 8'h14;
  localparam logic [7:0] OFS_FIRST_ERR = 8'h18;
  localparam logic [7:0] OFS_HDR_LOG0 = 8'h1c;
  localparam logic [7:0] OFS_HDR_LOG3 = 8'h28;
  localparam logic [7:0] OFS_DSN_HEADER = 8'h00;
  localparam logic [7:0] OFS_DSN_LOW = 8'h04;
  localparam logic [7:0] OFS_DSN_HIGH = 8'h08;

  // ----------------------------------------------------------------------
  // Capability header fields.
  // ----------------------------------------------------------------------
  localparam logic [15:0] AER_CAP_ID = 16'h0001;
  localparam logic [15:0] DSN_CAP_ID = 16'h0003;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_END = 12'h000;

  // ----------------------------------------------------------------------
  // Uncorrectable error bit positions.
  // ----------------------------------------------------------------------
  localparam int UNC_DLP = 4;
  localparam int UNC_POISON = 12;
  localparam int UNC_FCP = 13;
  localparam int UNC_CTO = 14;
  localparam int UNC_CA = 15;
  localparam int UNC_UC = 16;
  localparam int UNC_RO = 17;
  localparam int UNC_MTLP = 18;
  localparam int UNC_UR = 20;

  // ----------------------------------------------------------------------
  // Correctable error bit positions.
  // ----------------------------------------------------------------------
  localparam int COR_RX = 0;
  localparam int COR_BTLP = 6;
  localparam int COR_BDLLP = 7;
  localparam int COR_ROLL = 8;
  localparam int COR_RTO = 12;
  localparam int COR_ANF = 13;

  // ----------------------------------------------------------------------
  // Implemented bits and values after reset.
  // ----------------------------------------------------------------------
  localparam logic [31:0] UNC_IMPL = 32'h0017_f010;
  localparam logic [15:0] COR_IMPL = 16'h31c1;
  localparam logic [31:0] UNC_SUPPRESS_RST = 32'h0000_0000;
  localparam logic [31:0] UNC_FATALITY_RST = 32'h0006_2010;
  localparam logic [15:0] COR_SUPPRESS_RST = 16'h2000;
  localparam logic [31:0] UNC_FLAGS_RST = 32'h0000_0000;
  localparam logic [15:0] COR_FLAGS_RST = 16'h0000;
  localparam logic [3:0] FIRST_ERR_RST = 4'h0;
  localparam logic [127:0] HDR_LOG_RST = 128'h0;

  // ----------------------------------------------------------------------
  // Message kinds sent to the root complex.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCAER_MSG_COR,
    PCAER_MSG_NONFATAL,
    PCAER_MSG_FATAL
  } pcaer_msg_t;
endpackage

// ---- tb/pcaer_cap_regs_asserts.sv ----
`timescale 1ns/1ps
module pcaer_cap_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dsn_enable,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_hit,
  input wire logic [31:0] unc_err_evt,
  input wire logic [15:0] cor_err_evt,
  input wire logic msg_ack,
  input wire logic msg_req,
  input wire pcaer_pkg::pcaer_msg_t msg_type
);
  // ----------------------------------------------------------------
  // Port checks.
  // ----------------------------------------------------------------
  logic rd;
  logic [9:0] dw;
  assign rd = cfg_req && !cfg_wr;
  assign dw = cfg_addr[11:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_header_fixed: assert property (rd && dw == 10'h040 |=>
    cfg_rdata[19:0] == 20'h10001) else $error("header id wrong");
  a_next_ptr: assert property (rd && dw == 10'h040 |=>
    cfg_rdata[31:20] == ($past(dsn_enable) ? 12'h140 : 12'h000))
    else $error("next pointer wrong");
  a_unc_reserved: assert property (rd && dw inside {10'h041,
    10'h042, 10'h043} |=> (cfg_rdata & 32'hffe8_0fef) == 32'h0)
    else $error("uncorrectable reserved bit set");
  a_cor_reserved: assert property (rd && dw inside {
    10'h044, 10'h045} |=> (cfg_rdata & 32'hffff_ce3e) == 32'h0)
    else $error("correctable reserved bit set");
  a_ptr_width: assert property (rd && dw == 10'h046 |=>
    cfg_rdata[31:4] == 28'h0) else $error("pointer too wide");
  a_unmapped_read: assert property (rd && (dw < 10'h040 ||
    dw > (dsn_enable ? 10'h053 : 10'h04f)) |=> !cfg_hit &&
    cfg_rdata == 32'h0) else $error("unmapped read answered");
  a_msg_hold: assert property (msg_req && !msg_ack |=>
    msg_req && $stable(msg_type)) else $error("message dropped");
  a_no_spurious: assert property (!msg_req && unc_err_evt == 32'h0
    && cor_err_evt == 16'h0 |=> !msg_req)
    else $error("message without error");
endmodule

bind pcaer_cap_regs pcaer_cap_regs_chk u_chk (.clk(clk), .rst_n(rst_n),
  .dsn_enable(dsn_enable), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
  .unc_err_evt(unc_err_evt), .cor_err_evt(cor_err_evt),
  .msg_ack(msg_ack), .msg_req(msg_req), .msg_type(msg_type));

// ---- tb/pcaer_link_model.sv ----
`timescale 1ns/1ps
module pcaer_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msg_req,
  input wire pcaer_pkg::pcaer_msg_t msg_type,
  input wire logic [1:0] stall,
  output logic msg_ack,
  output pcaer_pkg::pcaer_msg_t last_ff
);
  // ----------------------------------------------------------------
  // Message acceptor with a chosen stall.
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [1:0] wait_ff;
  assign msg_ack = ack_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      wait_ff <= 2'h0;
      last_ff <= pcaer_pkg::PCAER_MSG_COR;
    end else if (msg_req && !ack_ff) begin
      ack_ff <= (wait_ff >= stall);
      wait_ff <= wait_ff + 2'h1;
    end else begin
      ack_ff <= 1'b0;
      wait_ff <= 2'h0;
      if (msg_req) begin
        last_ff <= msg_type;
      end
    end
  end
endmodule

// ---- tb/pcie_aer_capability_regs_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcie_aer_capability_regs_test;
  logic clk = 1'b0;
  logic rst_n, por_n, dsn_enable, cfg_req, cfg_wr, cfg_rvalid, cfg_hit;
  logic msg_ack, msg_req;
  logic [1:0] stall;
  logic [3:0] cfg_be;
  logic [11:0] cfg_addr;
  logic [15:0] cor_err_evt;
  logic [31:0] cfg_wdata, cfg_rdata, unc_err_evt, rd, sev, v;
  logic [31:0] seed = 32'h0001_8415;
  logic [63:0] serial_number;
  logic [127:0] err_header, hl;
  pcaer_pkg::pcaer_msg_t msg_type, last_type;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int i, k, p;
  int unc_pos[9] = '{4, 12, 13, 14, 15, 16, 17, 18, 20};
  int cor_pos[6] = '{0, 6, 7, 8, 12, 13};
  logic [31:0] rst_tab[11] = '{32'h0001_0001, 0, 0, 32'h0006_2010, 0,
    32'h2000, 0, 0, 0, 0, 0};
  // ----------------------------------------------------------------
  // Clock, design and partner.
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  pcaer_cap_regs DUT (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .dsn_enable(dsn_enable), .serial_number(serial_number),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit), .unc_err_evt(unc_err_evt),
    .cor_err_evt(cor_err_evt), .err_header(err_header),
    .msg_ack(msg_ack), .msg_req(msg_req), .msg_type(msg_type));
  pcaer_link_model u_link (.clk(clk), .rst_n(rst_n), .msg_req(msg_req),
    .msg_type(msg_type), .stall(stall), .msg_ack(msg_ack),
    .last_ff(last_type));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] exp_reg(int n, logic [31:0] w);
    case (n)
      0: return {dsn_enable ? 12'h140 : 12'h000, 4'h1, 16'h0001};
      2, 3: return w & 32'h0017_f010;
      5: return w & 32'h0000_31c1;
      default: return 32'h0;
    endcase
  endfunction
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_req = 1'b1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_req = 1'b0;
  endtask
  task rdc(input logic [11:0] a, output logic [31:0] d);
    logic h;
    h = a >= 12'h100 && a < (dsn_enable ? 12'h150 : 12'h140);
    @(negedge clk);
    cfg_req = 1'b1;
    cfg_wr = 1'b0;
    cfg_addr = a;
    @(negedge clk);
    cfg_req = 1'b0;
    d = cfg_rdata;
    `CHK("rvalid", 1'b1, cfg_rvalid)
    `CHK("hit", h, cfg_hit)
  endtask
  task evt(input logic [31:0] u, input logic [15:0] c, input logic e,
    input pcaer_pkg::pcaer_msg_t t);
    int n;
    @(negedge clk);
    unc_err_evt = u;
    cor_err_evt = c;
    err_header = hl;
    @(negedge clk);
    unc_err_evt = 32'h0;
    cor_err_evt = 16'h0;
    `CHK("msg_req", e, msg_req)
    if (e) begin
      `CHK("msg_type", t, msg_type)
      n = 0;
      while (msg_req === 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      `CHK("msg_taken", t, last_type)
    end
  endtask
  task reset(input logic pwr);
    @(negedge clk);
    rst_n = 1'b0;
    por_n = !pwr;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
  endtask
  task test_done();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {rst_n, por_n, dsn_enable, cfg_req, cfg_wr} = 5'h0;
    {cfg_addr, cfg_wdata, unc_err_evt, cor_err_evt, stall} = '0;
    cfg_be = 4'hf;
    err_header = 128'h0;
    hl = 128'h0;
    serial_number = {rnd(), rnd()};
    reset(1'b1);
    for (i = 0; i < 11; i++) begin
      rdc(12'h100 + 12'(4 * i), rd);
      `CHK("reset", rst_tab[i], rd)
    end
    rdc(12'h140, rd);
    `CHK("dsn_off", 32'h0, rd)
    rdc(12'h200, rd);
    `CHK("unmapped", 32'h0, rd)
    dsn_enable = 1'b1;
    rdc(12'h140, rd);
    `CHK("dsn_hdr", 32'h0001_0003, rd)
    rdc(12'h144, rd);
    `CHK("dsn_lo", serial_number[31:0], rd)
    rdc(12'h148, rd);
    `CHK("dsn_hi", serial_number[63:32], rd)
    for (i = 0; i < 8; i++) begin
      v = rnd();
      wr(12'h100 + 12'(4 * i), v);
      rdc(12'h100 + 12'(4 * i), rd);
      `CHK("access", exp_reg(i, v), rd)
    end
    rdc(12'h10c, sev);
    wr(12'h108, 32'h0);
    wr(12'h114, 32'h0);
    for (k = 0; k < 9; k++) begin
      p = unc_pos[k];
      hl = {rnd(), rnd(), rnd(), rnd()};
      v = rnd();
      stall = v[1:0];
      evt((32'h1 << p) | (v & 32'hffe8_0fef), 16'h0, 1'b1,
        sev[p] ? pcaer_pkg::PCAER_MSG_FATAL :
        pcaer_pkg::PCAER_MSG_NONFATAL);
      rdc(12'h118, rd);
      `CHK("first", 32'(p & 15), rd)
      for (i = 0; i < 4; i++) begin
        rdc(12'h11c + 12'(4 * i), rd);
        `CHK("log", hl[32 * i +: 32], rd)
      end
      wr(12'h104, 32'h0);
      rdc(12'h104, rd);
      `CHK("unc_set", 32'h1 << p, rd)
      wr(12'h104, 32'h1 << p);
      rdc(12'h104, rd);
      `CHK("unc_clr", 32'h0, rd)
    end
    wr(12'h108, 32'h0000_4000);
    evt(32'h4000, 16'h0, 1'b0, pcaer_pkg::PCAER_MSG_COR);
    for (k = 0; k < 6; k++) begin
      p = cor_pos[k];
      evt(32'h0, (16'h1 << p) | (16'(rnd()) & 16'hce3e), 1'b1,
        pcaer_pkg::PCAER_MSG_COR);
      rdc(12'h110, rd);
      `CHK("cor_set", 32'h1 << p, rd)
      wr(12'h110, 32'h1 << p);
      rdc(12'h110, rd);
      `CHK("cor_clr", 32'h0, rd)
    end
    reset(1'b0);
    rdc(12'h104, rd);
    `CHK("sticky", 32'h4000, rd)
    rdc(12'h108, rd);
    `CHK("sticky_mask", 32'h4000, rd)
    reset(1'b1);
    rdc(12'h104, rd);
    `CHK("por_clr", 32'h0, rd)
    evt(32'h0, 16'h2000, 1'b0, pcaer_pkg::PCAER_MSG_COR);
    cfg_be = 4'h2;
    wr(12'h10c, 32'h0);
    cfg_be = 4'hf;
    rdc(12'h10c, rd);
    `CHK("lane", 32'h0006_0010, rd)
    test_done();
  end
endmodule
